//--- pkg/serlink_defs.vh
// Shared constants for the video serial link transmitter
`ifndef SERLINK_DEFS_VH
`define SERLINK_DEFS_VH
// ==========================================
// Symbol layout
`define SYM_W 35
`define PAY_W 34
`define RGB_LSB 0
`define HS_BIT 24
`define VS_BIT 25
`define DE_BIT 26
`define SDA_BIT 27
`define SCL_BIT 28
`define GPIO_LSB 29
`define AUD_BIT 33
`define INV_BIT 34
// ==========================================
// Input frame
`define LANE_BITS 7
`define LANES 8
`define FRAME_W 28
`define CLK_PATTERN 7'h63
`define FIFO_DEPTH 16
`define FIFO_AW 4
// ==========================================
// Scrambler and balance
`define LFSR_SEED 16'hACE1
`define LFSR_TAPS 16'hB400
`define ONES_HALF 8'h11
// ==========================================
// Rate limits in MHz and Mbps
`define SYM_BITS 13'h0023
`define PCLK_MIN_1 8'h19
`define PCLK_MAX_1 8'h60
`define PCLK_MIN_2 8'h32
`define PCLK_MAX_2 8'hAA
`define LINE_MIN 13'h036B
`define LINE_MAX_1 13'h0D20
`define LINE_MAX_2 13'h0B9F
// ==========================================
// Back channel frame and register map
`define BC_W 16
`define BC_CNT_LAST 4'hF
`define CRC_POLY 4'h3
`define REG_MAP_CTRL 3'h0
`define REG_STATUS 3'h7
`define REG_MAP_EN_BIT 0
`define REG_MAP_VAL_BIT 1
`define PORT_EN_BIT 0
`endif

//--- verilog/sym_fifo.v
// Synchronous FIFO carrying symbol payloads toward the lane stage
`timescale 1ns/1ps
module sym_fifo #(
  parameter WIDTH = 34,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  // ==========================================
  // Storage and pointers
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Word store
  reg [AW:0] count; // Words held, read data word included
  reg [AW-1:0] wr_ptr; // Next write slot
  reg [AW-1:0] rd_ptr; // Next slot to move into out_data
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  // Read data register counts as one slot, so full is honest
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  // Slot that will be in out_data after a pop
  wire mem_has = (count > {{AW{1'b0}}, 1'b1});
  // ==========================================
  // Pointer, count and registered read data
  always @(posedge mclk) begin
    if (!rst_b) begin
      count <= {(AW+1){1'b0}};
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      // Empty or just drained: a new word goes straight to the output
      if (push && (count == {(AW+1){1'b0}} || (pop && !mem_has))) begin
        out_data <= in_data;
        rd_ptr <= wr_ptr + 1'b1;
      end else if (pop && mem_has) begin
        out_data <= mem[rd_ptr];
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sym_fifo

//--- verilog/port_regs.v
// Shared and per-port duplicated control registers with port steering
`timescale 1ns/1ps
`include "serlink_defs.vh"
module port_regs (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Register access from the local control slave
  input wire acc_wr,
  input wire [3:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire acc_second,
  output reg [7:0] acc_rdata,
  // Port steering
  input wire first_port_select_bit,
  input wire second_port_select_bit,
  input wire second_port_address_enable,
  // Block state and controls
  input wire [7:0] status,
  output wire [7:0] shared_ctrl,
  output wire [7:0] port0_ctrl,
  output wire [7:0] port1_ctrl
);
  // ==========================================
  // Storage: low half shared, high half duplicated per port
  reg [7:0] shared [0:7];
  reg [7:0] dup0 [0:7];
  reg [7:0] dup1 [0:7];
  wire is_dup = acc_addr[3];
  reg hit0; // Access reaches port 0 copy
  reg hit1; // Access reaches port 1 copy
  integer i;
  // ==========================================
  // Port steering decode
  always @* begin
    if (second_port_address_enable) begin
      hit0 = ~acc_second;
      hit1 = acc_second;
    end else begin
      hit0 = first_port_select_bit;
      hit1 = second_port_select_bit;
    end
  end
  // ==========================================
  // Writes; both copies may change in one access
  always @(posedge mclk) begin
    if (!rst_b) begin
      for (i = 0; i < 8; i = i + 1) begin
        shared[i] <= 8'h00;
        dup0[i] <= 8'h01;
        dup1[i] <= 8'h01;
      end
    end else if (acc_wr) begin
      if (!is_dup) begin
        shared[acc_addr[2:0]] <= acc_wdata;
      end else begin
        if (hit0) begin
          dup0[acc_addr[2:0]] <= acc_wdata;
        end
        if (hit1) begin
          dup1[acc_addr[2:0]] <= acc_wdata;
        end
        // No select bit set with second_port_address_enable low: no duplicated copy is written
      end
    end
  end
  // ==========================================
  // Registered read data
  always @(posedge mclk) begin
    if (!rst_b) begin
      acc_rdata <= 8'h00;
    end else if (!is_dup) begin
      if (acc_addr[2:0] == `REG_STATUS) begin
        acc_rdata <= status;
      end else begin
        acc_rdata <= shared[acc_addr[2:0]];
      end
    end else if (hit1) begin
      acc_rdata <= dup1[acc_addr[2:0]];
    end else begin
      acc_rdata <= dup0[acc_addr[2:0]];
    end
  end
  assign shared_ctrl = shared[`REG_MAP_CTRL];
  assign port0_ctrl = dup0[0];
  assign port1_ctrl = dup1[0];
endmodule // port_regs

//--- verilog/lvds_video_serial_link_tx.v
// Video serial link transmitter: pixel capture, symbol build, lanes, back channel
`timescale 1ns/1ps
`include "serlink_defs.vh"
module lvds_video_serial_link_tx (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Pixel input pins, deserialized per lane
  input wire pclk_pin,
  input wire [6:0] clk_lane,
  input wire [55:0] lane_data,
  output wire pixel_ready,
  // Straps and modes
  input wire colour_mapping_strap,
  input wire dual_pixel_mode,
  input wire dual_lane_mode,
  input wire [7:0] pclk_mhz,
  // Side-band inputs carried in the symbol
  input wire [3:0] gpio_in,
  input wire audio_bit,
  // Local I2C pins
  input wire scl_in,
  input wire sda_in,
  output wire scl_out,
  output wire scl_oe,
  output wire sda_out,
  output wire sda_oe,
  // Register access
  input wire acc_wr,
  input wire [3:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire acc_second,
  output wire [7:0] acc_rdata,
  input wire first_port_select_bit,
  input wire second_port_select_bit,
  input wire second_port_address_enable,
  // Forward lanes
  output reg [34:0] sym_a,
  output reg sym_valid_a,
  input wire sym_ready_a,
  output reg [34:0] sym_b,
  output reg sym_valid_b,
  input wire sym_ready_b,
  // Back channel from the lane receiver
  input wire bc_bit,
  input wire bc_bit_valid,
  input wire bc_frame_start,
  output reg [3:0] d_gpio,
  output reg [7:0] bc_i2c_byte,
  output reg bc_crc_err,
  // Status
  output reg frame_err,
  output reg overflow,
  output reg rate_ok
);
  // ==========================================
  // Pin synchronisers: first stage is read only by the second
  reg [75:0] sync1;
  reg [75:0] sync2;
  reg pclk_q; // Previous synchronised pixel clock level
  wire [75:0] pin_raw = {pclk_pin, clk_lane, lane_data, colour_mapping_strap,
    gpio_in, audio_bit, scl_in, sda_in, 4'h0};
  // Stages run through reset, so the strap and the pixel clock level are settled at release
  always @(posedge mclk) begin
    sync1 <= pin_raw;
    sync2 <= sync1;
    pclk_q <= sync2[75];
  end
  wire pclk_s = sync2[75];
  wire [6:0] clk_lane_s = sync2[74:68];
  wire [55:0] lanes_s = sync2[67:12];
  wire strap_s = sync2[11];
  wire [3:0] gpio_s = sync2[10:7];
  wire audio_s = sync2[6];
  wire scl_s = sync2[5];
  wire sda_s = sync2[4];
  wire frame_edge = pclk_s & ~pclk_q; // One frame per pixel clock
  // ==========================================
  // Register file
  wire [7:0] shared_ctrl;
  wire [7:0] port0_ctrl;
  wire [7:0] port1_ctrl;
  wire [7:0] status = {4'h0, bc_crc_err, overflow, frame_err, rate_ok};
  port_regs u_regs (
    .mclk(mclk),
    .rst_b(rst_b),
    .acc_wr(acc_wr),
    .acc_addr(acc_addr),
    .acc_wdata(acc_wdata),
    .acc_second(acc_second),
    .acc_rdata(acc_rdata),
    .first_port_select_bit(first_port_select_bit),
    .second_port_select_bit(second_port_select_bit),
    .second_port_address_enable(second_port_address_enable),
    .status(status),
    .shared_ctrl(shared_ctrl),
    .port0_ctrl(port0_ctrl),
    .port1_ctrl(port1_ctrl)
  );
  // ==========================================
  // Mapping strap caught once after reset release
  reg strap_taken;
  reg map_strap;
  always @(posedge mclk) begin
    if (!rst_b) begin
      strap_taken <= 1'b0;
      map_strap <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      map_strap <= strap_s;
    end
  end
  // Register override wins over the strap
  wire lsb_map = shared_ctrl[`REG_MAP_EN_BIT] ? shared_ctrl[`REG_MAP_VAL_BIT] : map_strap;
  // ==========================================
  // Frame to pixel: lanes 0-2 carry six bits per colour plus sync, lane 3 the rest
  function [26:0] map_pixel;
    input [27:0] f;
    input lsb;
    reg [5:0] r6;
    reg [5:0] g6;
    reg [5:0] b6;
    reg [5:0] x6;
    begin
      r6 = f[5:0];
      g6 = {f[11:7], f[6]};
      b6 = {f[17:14], f[13:12]};
      x6 = f[26:21];
      if (lsb) begin
        map_pixel = {f[20], f[19], f[18], b6, x6[1:0], g6, x6[3:2], r6, x6[5:4]};
      end else begin
        map_pixel = {f[20], f[19], f[18], x6[1:0], b6, x6[3:2], g6, x6[5:4], r6};
      end
    end
  endfunction
  // ==========================================
  // Capture: second pixel of a dual frame is queued one cycle later
  reg [26:0] pend_pix;
  reg pend_valid;
  reg [26:0] cap_pix;
  reg cap_valid;
  always @(posedge mclk) begin
    if (!rst_b) begin
      pend_pix <= 27'h000_0000;
      pend_valid <= 1'b0;
      cap_pix <= 27'h000_0000;
      cap_valid <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      cap_valid <= 1'b0;
      if (frame_edge) begin
        cap_pix <= map_pixel(lanes_s[27:0], lsb_map);
        cap_valid <= 1'b1;
        pend_pix <= map_pixel(lanes_s[55:28], lsb_map);
        pend_valid <= dual_pixel_mode;
        // Clock lane must show high 2, low 3, high 2
        frame_err <= (clk_lane_s != `CLK_PATTERN);
      end else if (pend_valid) begin
        cap_pix <= pend_pix;
        cap_valid <= 1'b1;
        pend_valid <= 1'b0;
      end
    end
  end
  // ==========================================
  // Payload build and FIFO; the pixel source cannot stall, so loss is flagged
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [33:0] fifo_out;
  wire [33:0] payload = {audio_s, gpio_s, scl_s, sda_s, cap_pix};
  assign pixel_ready = fifo_in_ready;
  always @(posedge mclk) begin
    if (!rst_b) begin
      overflow <= 1'b0;
    end else if (cap_valid && !fifo_in_ready) begin
      overflow <= 1'b1;
    end
  end
  sym_fifo #(
    .WIDTH(`PAY_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(cap_valid),
    .in_ready(fifo_in_ready),
    .in_data(payload),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );
  // ==========================================
  // Scrambler and DC balance
  reg [15:0] lfsr;
  reg signed [7:0] disparity; // Running half of ones minus zeros
  wire [33:0] scram = fifo_out ^ {lfsr[1:0], lfsr, lfsr};
  reg [7:0] ones;
  integer k;
  always @* begin
    ones = 8'h00;
    for (k = 0; k < `PAY_W; k = k + 1) begin
      ones = ones + {7'h00, scram[k]};
    end
  end
  wire signed [7:0] word_disp = $signed(ones) - $signed(`ONES_HALF);
  // Invert when the word would push disparity further the same way
  wire invert = (word_disp[7] == disparity[7]) && (word_disp != 8'h00);
  wire [34:0] symbol = {invert, invert ? ~scram : scram};
  // ==========================================
  // Lane steering: single lane uses A, dual alternates A and B
  reg lane_sel;
  wire port_en_a = port0_ctrl[`PORT_EN_BIT];
  wire port_en_b = port1_ctrl[`PORT_EN_BIT];
  wire free_a = (!sym_valid_a || sym_ready_a) && port_en_a;
  wire free_b = (!sym_valid_b || sym_ready_b) && port_en_b;
  wire to_b = dual_lane_mode & lane_sel;
  assign fifo_out_ready = to_b ? free_b : free_a;
  wire take = fifo_out_valid & fifo_out_ready;
  always @(posedge mclk) begin
    if (!rst_b) begin
      lfsr <= `LFSR_SEED;
      disparity <= 8'sh00;
      lane_sel <= 1'b0;
      sym_a <= 35'h0_0000_0000;
      sym_b <= 35'h0_0000_0000;
      sym_valid_a <= 1'b0;
      sym_valid_b <= 1'b0;
    end else begin
      if (sym_ready_a) begin
        sym_valid_a <= 1'b0;
      end
      if (sym_ready_b) begin
        sym_valid_b <= 1'b0;
      end
      if (take) begin
        // Galois step keeps the stream random per symbol
        lfsr <= lfsr[0] ? ((lfsr >> 1) ^ `LFSR_TAPS) : (lfsr >> 1);
        disparity <= invert ? disparity - word_disp : disparity + word_disp;
        lane_sel <= dual_lane_mode ? ~lane_sel : 1'b0;
        if (to_b) begin
          sym_b <= symbol;
          sym_valid_b <= 1'b1;
        end else begin
          sym_a <= symbol;
          sym_valid_a <= 1'b1;
        end
      end
    end
  end
  // ==========================================
  // Rate check: pixel clock range and per-lane line rate
  wire [12:0] line_full = {5'h00, pclk_mhz} * `SYM_BITS;
  wire [12:0] line_lane = dual_lane_mode ? {1'b0, line_full[12:1]} : line_full;
  always @(posedge mclk) begin
    if (!rst_b) begin
      rate_ok <= 1'b0;
    end else if (dual_lane_mode) begin
      rate_ok <= (pclk_mhz >= `PCLK_MIN_2) && (pclk_mhz <= `PCLK_MAX_2) &&
        (line_lane >= `LINE_MIN) && (line_lane <= `LINE_MAX_2);
    end else begin
      rate_ok <= (pclk_mhz >= `PCLK_MIN_1) && (pclk_mhz <= `PCLK_MAX_1) &&
        (line_lane >= `LINE_MIN) && (line_lane <= `LINE_MAX_1);
    end
  end
  // ==========================================
  // Back channel: 16-bit frame, gpio[3:0], i2c[11:4], crc[15:12]
  reg [15:0] bc_shift;
  reg [3:0] bc_cnt;
  reg bc_busy;
  reg remote_sda;
  reg remote_scl;
  wire [15:0] bc_next = {bc_bit, bc_shift[15:1]};
  function [3:0] crc4;
    input [11:0] d;
    integer j;
    reg fb;
    begin
      crc4 = 4'h0;
      for (j = 11; j >= 0; j = j - 1) begin
        fb = crc4[3] ^ d[j];
        crc4 = {crc4[2:0], 1'b0} ^ (fb ? `CRC_POLY : 4'h0);
      end
    end
  endfunction
  always @(posedge mclk) begin
    if (!rst_b) begin
      bc_shift <= 16'h0000;
      bc_cnt <= 4'h0;
      bc_busy <= 1'b0;
      d_gpio <= 4'h0;
      bc_i2c_byte <= 8'h00;
      bc_crc_err <= 1'b0;
      remote_sda <= 1'b1;
      remote_scl <= 1'b1;
    end else begin
      bc_crc_err <= 1'b0;
      if (bc_bit_valid) begin
        bc_shift <= bc_next;
        bc_cnt <= bc_frame_start ? 4'h1 : bc_cnt + 1'b1;
        bc_busy <= bc_frame_start | (bc_busy & (bc_cnt != `BC_CNT_LAST));
        if (bc_busy && !bc_frame_start && bc_cnt == `BC_CNT_LAST) begin
          if (crc4(bc_next[11:0]) == bc_next[15:12]) begin
            d_gpio <= bc_next[3:0];
            bc_i2c_byte <= bc_next[11:4];
            remote_sda <= bc_next[4];
            remote_scl <= bc_next[5];
          end else begin
            bc_crc_err <= 1'b1;
          end
        end
      end
    end
  end
  // ==========================================
  // Local I2C side: mirror remote lows so masters on both sides can arbitrate
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe = ~remote_sda;
  assign scl_oe = ~remote_scl;
endmodule // lvds_video_serial_link_tx

//--- verification/link_tx_checker.sv
// Port-level assertions for the video serial link transmitter
`timescale 1ns/1ps
module link_tx_checker (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Modes and register port
  input wire dual_lane_mode,
  input wire [7:0] pclk_mhz,
  input wire acc_wr,
  input wire [3:0] acc_addr,
  input wire [7:0] acc_rdata,
  // Forward lanes
  input wire [34:0] sym_a,
  input wire sym_valid_a,
  input wire sym_ready_a,
  input wire [34:0] sym_b,
  input wire sym_valid_b,
  input wire sym_ready_b,
  // Back channel, local bus and status
  input wire bc_bit_valid,
  input wire [3:0] d_gpio,
  input wire bc_crc_err,
  input wire scl_out,
  input wire sda_out,
  input wire pixel_ready,
  input wire overflow,
  input wire rate_ok
);
  // ==========================================
  // Common clocking
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // Expected rate verdict; line rate limits coincide with these pixel bounds
  wire rate_exp = dual_lane_mode ? (pclk_mhz >= 8'h32 && pclk_mhz <= 8'hAA) : (pclk_mhz >= 8'h19 && pclk_mhz <= 8'h60);
  // ==========================================
  // Sequences
  sequence s_cfg_steady;
    (rst_b && $stable(pclk_mhz) && $stable(dual_lane_mode))[*4];
  endsequence
  sequence s_stall_a;
    sym_valid_a && !sym_ready_a;
  endsequence
  sequence s_stall_b;
    sym_valid_b && !sym_ready_b;
  endsequence
  // Shared address held with no write; status at 7 excluded as it moves
  sequence s_shared_idle;
    (rst_b && !acc_wr && acc_addr < 4'h7 && $stable(acc_addr))[*3];
  endsequence
  // ==========================================
  // Assertions
  a_hold_lane_a: assert property (s_stall_a |=> sym_valid_a && $stable(sym_a))
    else $error("lane A symbol dropped or changed while stalled");
  a_hold_lane_b: assert property (s_stall_b |=> sym_valid_b && $stable(sym_b))
    else $error("lane B symbol dropped or changed while stalled");
  a_lane_b_dual: assert property ($rose(sym_valid_b) |-> dual_lane_mode)
    else $error("lane B used in single lane mode");
  a_rate_verdict: assert property (s_cfg_steady |-> rate_ok == rate_exp)
    else $error("rate verdict wrong for pixel clock");
  a_overflow_sticky: assert property (overflow |=> overflow)
    else $error("overflow flag cleared");
  a_overflow_cause: assert property ($rose(overflow) |-> !$past(pixel_ready) || !$past(pixel_ready, 2))
    else $error("overflow without a full buffer");
  a_crc_pulse: assert property (bc_crc_err |-> ($past(bc_bit_valid) || $past(bc_bit_valid, 2)) ##1 !bc_crc_err)
    else $error("crc error flag not a single pulse after a frame");
  a_gpio_cause: assert property (!$stable(d_gpio) |-> $past(bc_bit_valid) || $past(bc_bit_valid, 2))
    else $error("remote gpio changed without back channel bits");
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("local bus pin driven high");
  a_shared_stable: assert property (s_shared_idle |-> $stable(acc_rdata))
    else $error("shared register read moved without a write");
endmodule // link_tx_checker

//--- verification/video_far_side.sv
// Far side model: pixel source, lane sink and back channel sender
`timescale 1ns/1ps
module video_far_side (
  // Clock
  input wire mclk,
  // Pixel input pins
  output reg pclk_pin,
  output reg [6:0] clk_lane,
  output reg [55:0] lane_data,
  // Lane handshakes
  input wire sym_valid_a,
  input wire sym_valid_b,
  output reg sym_ready_a,
  output reg sym_ready_b,
  // Back channel stream
  output reg bc_bit,
  output reg bc_bit_valid,
  output reg bc_frame_start
);
  reg stall;  // Set by the bench to model a slow sink
  reg [6:0] clk_shape;  // Clock lane pattern per frame
  integer taken_a;
  integer taken_b;
  // ==========================================
  // Idle levels
  initial begin
    pclk_pin = 1'b0;
    clk_lane = 7'h00;
    lane_data = 56'h0000_0000_0000_00;
    sym_ready_a = 1'b1;
    sym_ready_b = 1'b1;
    bc_bit = 1'b0;
    bc_bit_valid = 1'b0;
    bc_frame_start = 1'b0;
    stall = 1'b0;
    clk_shape = 7'h63;
    taken_a = 0;
    taken_b = 0;
  end
  // Sink readiness follows the stall request
  always @(negedge mclk) begin
    sym_ready_a <= !stall;
    sym_ready_b <= !stall;
  end
  // Count accepted symbols per lane
  always @(posedge mclk) begin
    if (sym_valid_a && sym_ready_a) taken_a <= taken_a + 1;
    if (sym_valid_b && sym_ready_b) taken_b <= taken_b + 1;
  end
  // ==========================================
  // Frames of 800 ns; the pixel clock stands still between bursts
  task send_pixels(input integer n, input [55:0] pix);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        clk_lane = clk_shape;
        lane_data = pix + i;
        #400 pclk_pin = 1'b1;
        #400 pclk_pin = 1'b0;
      end
      // Released lines: no stale value left behind
      clk_lane = ~clk_lane;
      lane_data = ~lane_data;
    end
  endtask
  // One frame, bit 0 first, at the slowest rate: one bit every two cycles
  task send_bc(input [15:0] f);
    integer i;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        @(negedge mclk);
        bc_bit <= f[i];
        bc_bit_valid <= 1'b1;
        bc_frame_start <= (i == 0);
        @(negedge mclk);
        bc_bit <= ~f[i];
        bc_bit_valid <= 1'b0;
        bc_frame_start <= 1'b0;
      end
    end
  endtask
endmodule // video_far_side

//--- verification/lvds_video_serial_link_tx_test.sv
// Self-checking testbench for the video serial link transmitter
`timescale 1ns/1ps
module lvds_video_serial_link_tx_test;
  // ==========================================
  // Stimulus and observed signals
  reg mclk = 1'b0;
  reg rst_b = 1'b0;
  reg colour_mapping_strap = 1'b0;
  reg dual_pixel_mode = 1'b0;
  reg dual_lane_mode = 1'b0;
  reg [7:0] pclk_mhz = 8'h19;
  reg [3:0] gpio_in = 4'h5;
  reg audio_bit = 1'b0;
  reg acc_wr = 1'b0;
  reg [3:0] acc_addr = 4'h0;
  reg [7:0] acc_wdata = 8'h00;
  reg acc_second = 1'b0;
  reg first_port_select_bit = 1'b0;
  reg second_port_select_bit = 1'b0;
  reg second_port_address_enable = 1'b0;
  wire pclk_pin, pixel_ready, scl_out, scl_oe, sda_out, sda_oe;
  wire [6:0] clk_lane;
  wire [55:0] lane_data;
  wire [7:0] acc_rdata, bc_i2c_byte;
  wire [34:0] sym_a, sym_b;
  wire sym_valid_a, sym_ready_a, sym_valid_b, sym_ready_b;
  wire bc_bit, bc_bit_valid, bc_frame_start, bc_crc_err, frame_err, overflow, rate_ok;
  wire [3:0] d_gpio;
  // Pulled-up local bus: low only while the block pulls it
  wire scl_in = !scl_oe;
  wire sda_in = !sda_oe;
  integer err_total = 0;
  integer samples_checked = 0;
  integer crc_pulses = 0;
  integer i, a0, b0;
  // Rate table entries: {expected verdict, dual lane, MHz}
  localparam [79:0] RATE_TAB = {10'h1AB, 10'h3AA, 10'h131, 10'h332, 10'h061, 10'h260, 10'h018, 10'h219};
  lvds_video_serial_link_tx i_dut (.*);
  video_far_side i_far (.*);
  // Clock of 100 ns
  always #50 mclk = ~mclk;
  // Count error pulses from the back channel
  always @(posedge mclk) if (bc_crc_err === 1'b1) crc_pulses <= crc_pulses + 1;
  // ==========================================
  // Helpers
  task check(input [34:0] seen, input [34:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Register write with the selects given; entered at a falling edge
  task wrs(input s0, input s1, input [3:0] a, input [7:0] d);
    begin
      first_port_select_bit = s0;
      second_port_select_bit = s1;
      acc_addr = a;
      acc_wdata = d;
      acc_wr = 1'b1;
      @(negedge mclk);
      acc_wr = 1'b0;
    end
  endtask
  // Register read: data is answered one cycle after the address
  task rds(input s0, input s1, input [3:0] a, input [7:0] e);
    begin
      first_port_select_bit = s0;
      second_port_select_bit = s1;
      acc_addr = a;
      @(negedge mclk);
      check(acc_rdata, e);
    end
  endtask
  // Back channel check value, MSB first, x^4+x+1, zero start
  function [3:0] crc4(input [11:0] d);
    integer k;
    reg fb;
    begin
      crc4 = 4'h0;
      for (k = 11; k >= 0; k = k - 1) begin
        fb = crc4[3] ^ d[k];
        crc4 = {crc4[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
      end
    end
  endfunction
  task settle(input integer n);
    begin
      @(negedge mclk);
      repeat (n) @(negedge mclk);
    end
  endtask
  // ==========================================
  // Verdict, reached by the tests or the watchdog
  task report_and_stop;
    begin
      $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #400000;
    err_total = err_total + 1;
    report_and_stop;
  end
  // ==========================================
  // Test sequence
  initial begin
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
    // Port steering of duplicated and shared registers
    rds(1, 0, 4'h8, 8'h01);
    wrs(1, 1, 4'h9, 8'h5A);
    rds(1, 0, 4'h9, 8'h5A);
    rds(0, 1, 4'h9, 8'h5A);
    wrs(1, 0, 4'h9, 8'h11);
    rds(1, 1, 4'h9, 8'h5A);
    rds(1, 0, 4'h9, 8'h11);
    wrs(0, 0, 4'h9, 8'h77);
    rds(0, 0, 4'h9, 8'h11);
    rds(0, 1, 4'h9, 8'h5A);
    second_port_address_enable = 1'b1;
    acc_second = 1'b1;
    wrs(1, 0, 4'h9, 8'h99);
    rds(1, 0, 4'h9, 8'h99);
    acc_second = 1'b0;
    rds(0, 1, 4'h9, 8'h11);
    second_port_address_enable = 1'b0;
    rds(0, 1, 4'h9, 8'h99);
    wrs(0, 0, 4'h1, 8'h3C);
    rds(0, 1, 4'h1, 8'h3C);
    rds(1, 1, 4'h1, 8'h3C);
    // Pixel clock bounds for both lane modes
    for (i = 0; i < 8; i = i + 1) begin
      dual_lane_mode = RATE_TAB[i*10+8];
      pclk_mhz = RATE_TAB[i*10 +: 8];
      repeat (6) @(negedge mclk);
      check(rate_ok, RATE_TAB[i*10+9]);
    end
    dual_lane_mode = 1'b0;
    pclk_mhz = 8'h19;
    repeat (6) @(negedge mclk);
    // One symbol per pixel on a single lane
    a0 = i_far.taken_a;
    b0 = i_far.taken_b;
    i_far.send_pixels(4, 56'h0012_3456_789A_BC);
    settle(20);
    check(i_far.taken_a - a0, 4);
    check(i_far.taken_b - b0, 0);
    // Dual pixel over two lanes: two symbols per frame, shared out
    dual_lane_mode = 1'b1;
    dual_pixel_mode = 1'b1;
    pclk_mhz = 8'h64;
    a0 = i_far.taken_a;
    b0 = i_far.taken_b;
    i_far.send_pixels(3, 56'h00F0_F0F0_0F0F_0F);
    settle(20);
    check(i_far.taken_a - a0, 3);
    check(i_far.taken_b - b0, 3);
    dual_lane_mode = 1'b0;
    dual_pixel_mode = 1'b0;
    pclk_mhz = 8'h19;
    // Broken clock lane pattern, then a good frame
    i_far.clk_shape = 7'h3C;
    i_far.send_pixels(1, 56'h0000_0000_0000_01);
    settle(10);
    check(frame_err, 1'b1);
    i_far.clk_shape = 7'h63;
    i_far.send_pixels(1, 56'h0000_0000_0000_02);
    settle(10);
    check(frame_err, 1'b0);
    // Fill the buffer against a stalled sink, then drain it
    check(overflow, 1'b0);
    i_far.stall = 1'b1;
    a0 = i_far.taken_a;
    i_far.send_pixels(24, 56'h0055_AA55_AA55_AA);
    settle(4);
    check(pixel_ready, 1'b0);
    check(overflow, 1'b1);
    i_far.stall = 1'b0;
    settle(60);
    check((i_far.taken_a - a0) >= 16, 1'b1);
    check(pixel_ready, 1'b1);
    check(overflow, 1'b1);
    // Back channel frames: remote bus low, then released, then bad check value
    i_far.send_bc({crc4(12'h0CA), 12'h0CA});
    settle(3);
    check(d_gpio, 4'hA);
    check(bc_i2c_byte, 8'h0C);
    check({scl_oe, sda_oe}, 2'b11);
    i_far.send_bc({crc4(12'h035), 12'h035});
    settle(3);
    check(d_gpio, 4'h5);
    check({scl_oe, sda_oe}, 2'b00);
    check(crc_pulses, 0);
    i_far.send_bc({crc4(12'h0C6) ^ 4'h1, 12'h0C6});
    settle(3);
    check(crc_pulses, 1);
    report_and_stop;
  end
endmodule // lvds_video_serial_link_tx_test
bind lvds_video_serial_link_tx link_tx_checker i_chk (.mclk, .rst_b, .dual_lane_mode, .pclk_mhz, .acc_wr, .acc_addr,
  .acc_rdata, .sym_a, .sym_valid_a, .sym_ready_a, .sym_b, .sym_valid_b, .sym_ready_b, .bc_bit_valid, .d_gpio,
  .bc_crc_err, .scl_out, .sda_out, .pixel_ready, .overflow, .rate_ok);
